// file: verilog/mesh_memory_event_selector_params.svh
// Offsets, field positions and reset values of the event selector
// Overview of operation
// - Code 0x38 counts writes sent to the memory controller, by mask.
// - Scrub writes from error-correction errors never count as writes.
// - For writes, mask bit 0 selects full-line non-isochronous writes.
// - For writes, mask bit 1 selects partial non-isochronous writes.
// - For writes, mask bit 2 selects isochronous full-line writes.
// - For writes, mask bit 3 selects isochronous partial writes.
// - For writes, mask bit 4 selects every write whatever its class.
// - For writes, mask bit 6 selects writes to memory used as a cache.
// - For writes, mask bit 7 selects all writes to persistent modules.
// - Code 0x4c counts header matches, bit 0 mesh, bit 1 controller.
// - Code 0x6b counts prefetch-table-full cycles, bits 0 to 2 per lane.
// - Code 0x6c counts prefetch-table-not-empty cycles, same mask.
// - Code 0x6e counts prefetch table releases, mask bits per cause.
// - Code 0x6f counts dropped prefetches, crossbar or link per lane.
// - Code 0x74 counts demands merged with held prefetches, per lane.
// - Code 0x64 counts mirror tracker inserts, 0x65 adds occupancy.
`ifndef MESH_MEMORY_EVENT_SELECTOR_PARAMS_SVH
`define MESH_MEMORY_EVENT_SELECTOR_PARAMS_SVH

// Register map, one control and one count word per counter
`define MMS_CTL_OFFSET   12'h000
`define MMS_CNT_OFFSET   12'h004
`define MMS_STRIDE_LSB   3
`define MMS_KIND_BIT     2

// Control word fields
`define MMS_CODE_LSB     0
`define MMS_MASK_LSB     8
`define MMS_CHAN_LSB     16
`define MMS_EN_BIT       22

// Reset values
`define MMS_CODE_RESET   8'h00
`define MMS_MASK_RESET   8'h00
`define MMS_CHAN_RESET   3'h7
`define MMS_EN_RESET     1'b0

// Memory write mask bits
`define MMS_WR_FULL      0
`define MMS_WR_PART      1
`define MMS_WR_ISO_FULL  2
`define MMS_WR_ISO_PART  3
`define MMS_WR_ALL       4
`define MMS_WR_MEM       5
`define MMS_WR_CACHE     6
`define MMS_WR_PMM       7

// Header match mask bits
`define MMS_HM_MESH      0
`define MMS_HM_CTRL      1

`endif

// file: verilog/mesh_memory_event_selector_pkg.sv
// Types shared by the event selector modules
package mesh_memory_event_selector_pkg;

    typedef enum logic [7:0] {
        EV_MEMORY_WRITE  = 8'h38,
        EV_HEADER_MATCH  = 8'h4c,
        EV_MIRROR_INSERT = 8'h64,
        EV_MIRROR_FILL   = 8'h65,
        EV_PF_FULL       = 8'h6b,
        EV_PF_NONEMPTY   = 8'h6c,
        EV_PF_RELEASE    = 8'h6e,
        EV_PF_DROP       = 8'h6f,
        EV_DEMAND_MERGE  = 8'h74
    } event_code_t;

    typedef enum logic [1:0] {
        REG_CTL   = 2'b01,
        REG_CNT   = 2'b10,
        REG_NONE  = 2'b00
    } reg_kind_t;

endpackage

// file: verilog/counter_if.sv
// Increment and load path between selector and one counter
`timescale 1ns/1ps
interface counter_if #(
    parameter int W = 32
);
    logic [W-1:0] inc;
    logic         load;
    logic [W-1:0] load_value;
    logic [W-1:0] count;

    modport owner   (output inc, load, load_value, input count);
    modport counter (input inc, load, load_value, output count);
endinterface

// file: verilog/event_counter.sv
// One accumulating event counter with software load
`timescale 1ns/1ps
module event_counter #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Selector side
    counter_if.counter       port
);
    logic [W-1:0] count;

    // Load from software wins over counting in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (port.load) begin
            count <= port.load_value;
        end else begin
            count <= count + port.inc;
        end
    end

    assign port.count = count;
endmodule

// file: verilog/mesh_memory_event_selector.sv
// Event selection, control registers and APB slave
`timescale 1ns/1ps
`include "mesh_memory_event_selector_params.svh"
module mesh_memory_event_selector #(
    parameter int NUM_CNT = 4,
    parameter int COUNT_W = 32,
    parameter int OCC_W   = 8,
    parameter int ADDR_W  = 12
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Memory write requests, one bit per channel
    input  wire logic [2:0]        wr_valid,
    input  wire logic [2:0]        wr_partial,
    input  wire logic [2:0]        wr_isoch,
    input  wire logic [2:0]        wr_scrub,
    input  wire logic [2:0]        wr_to_mem,
    input  wire logic [2:0]        wr_to_cache,
    input  wire logic [2:0]        wr_persistent_module_writes,
    // Header match pulses
    input  wire logic              match_mesh,
    input  wire logic              match_ctrl,
    // Mirror write tracker
    input  wire logic              mirror_insert,
    input  wire logic [OCC_W-1:0]  mirror_fill,
    // Prefetch table, per channel, releases per cause
    input  wire logic [2:0]        pf_full,
    input  wire logic [2:0]        pf_nonempty,
    input  wire logic [7:0]        pf_release,
    input  wire logic [2:0]        pf_drop_xbar,
    input  wire logic [2:0]        pf_drop_link,
    input  wire logic [2:0]        pf_merge
);
    localparam int IDX_W = $clog2(NUM_CNT);

    // Control state per counter
    logic [7:0]         ctl_code [NUM_CNT];
    logic [7:0]         ctl_mask [NUM_CNT];
    logic [2:0]         ctl_chan [NUM_CNT];
    logic               ctl_en   [NUM_CNT];
    logic [COUNT_W-1:0] cnt_val  [NUM_CNT];
    logic [NUM_CNT-1:0] cnt_load;

    // Address decode
    mesh_memory_event_selector_pkg::reg_kind_t kind;
    logic [IDX_W-1:0] idx;
    logic             idx_ok;
    logic             access_edge;

    assign idx = paddr[`MMS_STRIDE_LSB +: IDX_W];
    assign idx_ok = (paddr[ADDR_W-1:`MMS_STRIDE_LSB+IDX_W] == '0)
                    && (32'(idx) < NUM_CNT) && (paddr[1:0] == 2'b00);
    assign access_edge = psel && penable && pready;

    always_comb begin
        if (!idx_ok) begin
            kind = mesh_memory_event_selector_pkg::REG_NONE;
        end else if (paddr[`MMS_KIND_BIT]) begin
            kind = mesh_memory_event_selector_pkg::REG_CNT;
        end else begin
            kind = mesh_memory_event_selector_pkg::REG_CTL;
        end
    end

    // Answer one cycle after setup, data and error registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable
                       && kind == mesh_memory_event_selector_pkg::REG_NONE;
            if (psel && !penable && !pwrite) begin
                unique case (kind)
                    mesh_memory_event_selector_pkg::REG_CTL: begin
                        prdata <= {9'h000, ctl_en[idx], 3'h0,
                                   ctl_chan[idx], ctl_mask[idx],
                                   ctl_code[idx]};
                    end
                    mesh_memory_event_selector_pkg::REG_CNT: begin
                        prdata <= 32'(cnt_val[idx]);
                    end
                    mesh_memory_event_selector_pkg::REG_NONE: begin
                        prdata <= 32'h0000_0000;
                    end
                endcase
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Control word writes take effect at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                ctl_code[i] <= `MMS_CODE_RESET;
                ctl_mask[i] <= `MMS_MASK_RESET;
                ctl_chan[i] <= `MMS_CHAN_RESET;
                ctl_en[i]   <= `MMS_EN_RESET;
            end
        end else if (access_edge && pwrite
                     && kind == mesh_memory_event_selector_pkg::REG_CTL) begin
            ctl_code[idx] <= pwdata[`MMS_CODE_LSB +: 8];
            ctl_mask[idx] <= pwdata[`MMS_MASK_LSB +: 8];
            ctl_chan[idx] <= pwdata[`MMS_CHAN_LSB +: 3];
            ctl_en[idx]   <= pwdata[`MMS_EN_BIT];
        end
    end

    // Count word writes load the counter
    always_comb begin
        cnt_load = '0;
        if (access_edge && pwrite
            && kind == mesh_memory_event_selector_pkg::REG_CNT) begin
            cnt_load[idx] = 1'b1;
        end
    end

    // Scrub writes are removed before any class is looked at
    logic [2:0] wr_live;
    assign wr_live = wr_valid & ~wr_scrub;

    // One selector and counter per slot
    for (genvar g = 0; g < NUM_CNT; g++) begin : g_slot
        counter_if #(.W(COUNT_W)) cif ();
        logic [7:0]         m;
        logic [2:0]         wr_sel;
        logic [2:0]         wr_cls;
        logic               hit;
        logic [COUNT_W-1:0] amount;

        assign m = ctl_mask[g];

        // Write classes chosen by the mask, per channel
        always_comb begin
            for (int c = 0; c < 3; c++) begin
                wr_cls[c] =
                    (m[`MMS_WR_FULL] && !wr_isoch[c]
                        && !wr_partial[c])
                    || (m[`MMS_WR_PART] && !wr_isoch[c]
                        && wr_partial[c])
                    || (m[`MMS_WR_ISO_FULL] && wr_isoch[c]
                        && !wr_partial[c])
                    || (m[`MMS_WR_ISO_PART] && wr_isoch[c]
                        && wr_partial[c])
                    || m[`MMS_WR_ALL]
                    || (m[`MMS_WR_MEM] && wr_to_mem[c])
                    || (m[`MMS_WR_CACHE] && wr_to_cache[c])
                    || (m[`MMS_WR_PMM] && wr_persistent_module_writes[c]);
            end
            wr_sel = wr_live & ctl_chan[g] & wr_cls;
        end

        // Event code selects which condition group drives the count
        always_comb begin
            hit    = 1'b0;
            amount = '0;
            unique case (ctl_code[g])
                mesh_memory_event_selector_pkg::EV_MEMORY_WRITE: begin
                    hit = |wr_sel;
                end
                mesh_memory_event_selector_pkg::EV_HEADER_MATCH: begin
                    hit = (m[`MMS_HM_MESH] && match_mesh)
                          || (m[`MMS_HM_CTRL] && match_ctrl);
                end
                mesh_memory_event_selector_pkg::EV_MIRROR_INSERT: begin
                    hit = mirror_insert;
                end
                mesh_memory_event_selector_pkg::EV_MIRROR_FILL: begin
                    amount = COUNT_W'(mirror_fill);
                end
                mesh_memory_event_selector_pkg::EV_PF_FULL: begin
                    hit = |(m[2:0] & pf_full);
                end
                mesh_memory_event_selector_pkg::EV_PF_NONEMPTY: begin
                    hit = |(m[2:0] & pf_nonempty);
                end
                mesh_memory_event_selector_pkg::EV_PF_RELEASE: begin
                    hit = |(m & pf_release);
                end
                mesh_memory_event_selector_pkg::EV_PF_DROP: begin
                    hit = |(m[5:0] & {pf_drop_link[2], pf_drop_xbar[2],
                                      pf_drop_link[1], pf_drop_xbar[1],
                                      pf_drop_link[0],
                                      pf_drop_xbar[0]});
                end
                mesh_memory_event_selector_pkg::EV_DEMAND_MERGE: begin
                    hit = (m[0] && pf_merge[0]) || (m[2] && pf_merge[1])
                          || (m[4] && pf_merge[2]);
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
            if (hit) begin
                amount = COUNT_W'(1);
            end
        end

        // Disabled slots and unmatched codes leave the count still
        assign cif.inc        = ctl_en[g] ? amount : '0;
        assign cif.load       = cnt_load[g];
        assign cif.load_value = pwdata[COUNT_W-1:0];
        assign cnt_val[g]     = cif.count;

        event_counter #(.W(COUNT_W)) u_counter (
            .pclk    (pclk),
            .presetn (presetn),
            .port    (cif.counter)
        );
    end
endmodule

// file: tb/mesh_memory_event_selector_checker.sv
// APB handshake checks for the event selector
`timescale 1ns/1ps
module mesh_memory_event_selector_checker #(
    parameter int NUM_CNT = 4,
    parameter int ADDR_W  = 12
) (
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Setup phase and address decode
    logic setup;
    logic bad;
    assign setup = psel && !penable;
    assign bad   = (paddr[1:0] != 2'b00) || (int'(paddr) >= NUM_CNT * 8);

    a_setup_gets_ready: assert property (setup |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property ($rose(pready) |-> $past(setup))
        else $error("ready without setup");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error outside access");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    a_write_data_zero: assert property (pready && pwrite |-> prdata == 0)
        else $error("read data on write");
    a_bad_refused: assert property (setup && bad |=> pslverr)
        else $error("unmapped access accepted");
    a_good_accepted: assert property (setup && !bad |=> !pslverr)
        else $error("mapped access refused");
endmodule

bind mesh_memory_event_selector mesh_memory_event_selector_checker #(
    .NUM_CNT (NUM_CNT),
    .ADDR_W  (ADDR_W)
) i_chk (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
);

// file: tb/tb.sv
// Random event stimulus and count checks for the event selector
`timescale 1ns/1ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, rd, a, b, exp_cnt;
    logic [2:0]  wr_valid, wr_partial, wr_isoch, wr_scrub, wr_to_mem;
    logic [2:0]  wr_to_cache, wr_persistent_module_writes, pf_full, pf_nonempty;
    logic [2:0]  pf_drop_xbar, pf_drop_link, pf_merge;
    logic        match_mesh, match_ctrl, mirror_insert, er;
    logic [7:0]  mirror_fill, pf_release;
    int          failures, n_checks;
    logic [7:0]  codes [10] = '{8'h38, 8'h4c, 8'h64, 8'h65, 8'h6b,
                                8'h6c, 8'h6e, 8'h6f, 8'h74, 8'h37};

    mesh_memory_event_selector i_dut (.*);

    // Clock
    initial begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected increment for this cycle's inputs
    function automatic logic [31:0] inc_of(input logic [7:0] c, m,
                                           input logic [2:0] ch);
        logic h;
        logic [2:0] w;
        h = 0;
        w = wr_valid & ~wr_scrub & ch;
        for (int i = 0; i < 3; i++) begin
            if (w[i]) begin
                h |= m[0] & !wr_partial[i] & !wr_isoch[i];
                h |= m[1] & wr_partial[i] & !wr_isoch[i];
                h |= m[2] & !wr_partial[i] & wr_isoch[i];
                h |= m[3] & wr_partial[i] & wr_isoch[i];
                h |= m[4] | (m[5] & wr_to_mem[i]);
                h |= (m[6] & wr_to_cache[i]) | (m[7] & wr_persistent_module_writes[i]);
            end
        end
        case (c)
            8'h38: ;
            8'h4c: h = (m[0] & match_mesh) | (m[1] & match_ctrl);
            8'h64: h = mirror_insert;
            8'h65: return {24'h00_0000, mirror_fill};
            8'h6b: h = |(m[2:0] & pf_full);
            8'h6c: h = |(m[2:0] & pf_nonempty);
            8'h6e: h = |(m & pf_release);
            8'h6f: h = |(m[5:0] & {pf_drop_link[2], pf_drop_xbar[2],
                pf_drop_link[1], pf_drop_xbar[1], pf_drop_link[0],
                pf_drop_xbar[0]});
            8'h74: h = |({m[4], m[2], m[0]} & pf_merge);
            default: h = 0;
        endcase
        return {31'h0000_0000, h};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 50) begin
            failures++;
            $display("MISMATCH pready expected 1 seen %b", pready);
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic set_inputs(input logic [31:0] x, y, input logic sc);
        {wr_valid, wr_partial, wr_isoch, wr_to_mem, wr_to_cache,
         wr_persistent_module_writes, match_mesh, match_ctrl, mirror_insert} <= x[20:0];
        wr_scrub <= sc ? 3'h7 : x[23:21] & x[26:24];
        {pf_merge, pf_drop_link, pf_drop_xbar, pf_release, pf_nonempty,
         pf_full, mirror_fill} <= y[30:0];
    endtask

    // One counting window on counter k
    task automatic run(input int k, input logic [7:0] c, m,
                       input logic [2:0] ch, input logic sc);
        logic [11:0] base;
        base = 12'(k * 8);
        exp_cnt = 0;
        apb(1, base + 12'h004, 32'h0000_0000);
        apb(1, base, {9'h000, 1'b1, 3'h0, ch, m, c});
        repeat (24) begin
            @(posedge pclk);
            seed = lfsr(seed);
            a = seed;
            seed = lfsr(seed);
            b = seed;
            set_inputs(a, b, sc);
            #1 exp_cnt += inc_of(c, m, ch);
        end
        @(posedge pclk);
        set_inputs(32'h0000_0000, 32'h0000_0000, 0);
        apb(1, base, {9'h000, 1'b0, 3'h0, ch, m, c});
        apb(0, base, 32'h0000_0000);
        chk("control", {9'h000, 1'b0, 3'h0, ch, m, c}, rd);
        apb(0, base + 12'h004, 32'h0000_0000);
        chk("count", exp_cnt, rd);
        $display("test code %h mask %h done", c, m);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        #(8 * 40000);
        failures++;
        finish_test();
    end

    // Main sequence
    initial begin
        presetn = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 32'h0001_5255;
        set_inputs(32'h0000_0000, 32'h0000_0000, 0);
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h000, 32'h0000_0000);
        chk("control reset", 32'h0007_0000, rd);
        apb(0, 12'h01c, 32'h0000_0000);
        chk("count reset", 32'h0000_0000, rd);
        apb(0, 12'h020, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, {rd[30:0], er});
        apb(1, 12'h002, 32'hffff_ffff);
        chk("misaligned", 32'h0000_0001, {31'h0, er});
        for (int i = 0; i < 8; i++) begin
            run(i % 4, 8'h38, 8'(1 << i), 3'h7, 0);
        end
        run(1, 8'h38, 8'hff, 3'h7, 1);
        run(2, 8'h38, 8'h10, 3'h2, 0);
        run(3, 8'h6b, 8'h07, 3'h7, 0);
        for (int i = 0; i < 20; i++) begin
            seed = lfsr(seed);
            run(i % 4, codes[i % 10], seed[7:0], seed[10:8], 0);
        end
        finish_test();
    end
endmodule
